// File: hw/tphi_pkg.sv
// Register map, field layout and timing constants of the time processor host interface
package tphi_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [5:0] TPHI_OFF_LATCH   = 6'h0a;
   localparam logic [5:0] TPHI_OFF_TIME_WORD   = 6'h0c;
   localparam logic [5:0] TPHI_OFF_EVENT_TIME_FIRST_WORD  = 6'h16;
   localparam logic [5:0] TPHI_OFF_RELEASE = 6'h20;
   localparam logic [5:0] TPHI_OFF_HSHAKE  = 6'h22;
   localparam logic [5:0] TPHI_OFF_CTRL    = 6'h24;
   localparam logic [5:0] TPHI_OFF_FIFO    = 6'h27;
   localparam logic [5:0] TPHI_OFF_MASK    = 6'h28;
   localparam logic [5:0] TPHI_OFF_STATUS  = 6'h2a;
   localparam logic [5:0] TPHI_OFF_VECTOR  = 6'h2c;
   localparam logic [5:0] TPHI_OFF_LEVEL   = 6'h2e;
   // ==========================================================
   // Field positions
   localparam int TPHI_CTRL_EVT_EN   = 0;
   localparam int TPHI_CTRL_LOCKOUT  = 3;
   localparam int TPHI_HS_ACCEPT     = 0;
   localparam int TPHI_HS_RESP       = 2;
   localparam int TPHI_HS_EXEC       = 7;
   localparam int TPHI_IRQ_EVENT     = 0;
   localparam int TPHI_IRQ_PERIODIC  = 1;
   localparam int TPHI_IRQ_STROBE    = 2;
   localparam int TPHI_IRQ_EPOCH     = 3;
   localparam int TPHI_IRQ_PACKET    = 4;
   localparam int TPHI_IRQ_BITS      = 5;
   localparam int TPHI_TIME_WORDS    = 5;
   localparam int TPHI_LEVEL_BITS    = 3;
   localparam int TPHI_VECTOR_BITS   = 8;
   // ==========================================================
   // Packet framing bytes
   localparam logic [7:0] TPHI_PKT_START = 8'h01;
   localparam logic [7:0] TPHI_PKT_END   = 8'h17;
   // ==========================================================
   // Reset values
   localparam logic [15:0] TPHI_RST_WORD = 16'h0000;
   // ==========================================================
   // Timing
   localparam int TPHI_CLK_HZ       = 25_000_000;
   localparam int TPHI_DISP_ADV_MS  = 990;
   localparam int TPHI_DISP_ADV_CYC = (TPHI_CLK_HZ / 1000) * TPHI_DISP_ADV_MS;
endpackage : tphi_pkg

// File: hw/tphi_top.sv
// Host register interface of the time processor
//
// Overview of operation
// - Reading the latch request register snapshots current time into holding words.
// - Control value 0x09 enables rising edge event capture plus lockout.
// - Event time reads as five words; reading release register clears lockout.
// - Mask bit 0 lets event status drive interrupt at programmed level, vector.
// - Status bits clear on writing one; bit 3 sets each epoch, bit 0 on event.
// - Processor sets handshake bit 0 on acceptance; host polls it before next packet.
// - Periodic output divides by two count-minus-one fields, synchronised to the epoch.
// - Displayed hours minutes seconds advance 990 ms into each second frame.
// - While flywheeling all display decimal points are lit.
// - Response ready sets handshake bit 2; host clears it writing bit 2.
`timescale 1ns/10ps
module tphi_top
   import tphi_pkg::*;
#(
   parameter int FIFO_DEPTH   = 64,
   parameter int DISP_ADV_CYC = TPHI_DISP_ADV_CYC
) (
   input  wire logic        SYS_CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic [5:0]  BUS_ADDR_I,
   input  wire logic        BUS_RD_I,
   input  wire logic        BUS_WR_I,
   input  wire logic [15:0] BUS_WDATA_I,
   output logic      [15:0] BUS_RDATA_O,
   output logic             BUS_ACK_O,
   input  wire logic [79:0] TIME_I,
   input  wire logic        EPOCH_I,
   input  wire logic        EVENT_I,
   input  wire logic        STROBE_I,
   input  wire logic        FLYWHEEL_I,
   input  wire logic [23:0] HMS_NEXT_I,
   input  wire logic [15:0] PER_N1_I,
   input  wire logic [15:0] PER_N2_I,
   output logic             PKT_EXEC_O,
   output logic [7:0]       PKT_DATA_O,
   output logic             PKT_VALID_O,
   input  wire logic        PKT_READ_I,
   input  wire logic        PKT_ACCEPT_I,
   input  wire logic        RESP_READY_I,
   output logic             IRQ_O,
   output logic [2:0]       IRQ_LEVEL_O,
   output logic [7:0]       IRQ_VECTOR_O,
   output logic             PERIODIC_O,
   output logic [23:0]      DISP_HMS_O,
   output logic             DISP_DP_O
);
   localparam int PW = $clog2(FIFO_DEPTH + 1);
   localparam int FW = $clog2(FIFO_DEPTH);
   localparam logic [31:0] DISP_ADV = 32'(DISP_ADV_CYC);

   // ==========================================================
   // Reset release
   logic rst_s1_r;
   logic rst_n;
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   // ==========================================================
   // State
   logic [79:0]               tlatch_r, tlatch_nxt;
   logic [79:0]               evtime_r, evtime_nxt;
   logic                      locked_r, locked_nxt;
   logic                      evt_d_r, evt_d_nxt;
   logic [15:0]               ctrl_r, ctrl_nxt;
   logic [15:0]               mask_r, mask_nxt;
   logic [TPHI_IRQ_BITS-1:0]  stat_r, stat_nxt;
   logic [7:0]                vec_r, vec_nxt;
   logic [2:0]                lvl_r, lvl_nxt;
   logic                      hs_acc_r, hs_acc_nxt;
   logic                      hs_resp_r, hs_resp_nxt;
   logic                      busy_r, busy_nxt;
   logic                      end_seen_r, end_seen_nxt;
   logic [PW-1:0]             wptr_r, wptr_nxt;
   logic [PW-1:0]             rptr_r, rptr_nxt;
   logic                      exec_r, exec_nxt;
   logic [15:0]               rdata_r, rdata_nxt;
   logic                      ack_r, ack_nxt;
   logic [31:0]               frame_r, frame_nxt;
   logic [23:0]               disp_r, disp_nxt;
   logic [15:0]               pc1_r, pc1_nxt;
   logic [15:0]               pc2_r, pc2_nxt;
   logic                      per_r, per_nxt;
   logic [7:0]                pkt_data_r;
   logic [7:0]                fifo_mem [FIFO_DEPTH];
   logic                      fifo_wr;
   logic                      evt_edge;
   logic                      capture;
   logic [TPHI_IRQ_BITS-1:0]  stat_set;
   logic                      per_tick;

   // ==========================================================
   // Next state
   always_comb begin
      tlatch_nxt   = tlatch_r;
      evtime_nxt   = evtime_r;
      locked_nxt   = locked_r;
      evt_d_nxt    = EVENT_I;
      ctrl_nxt     = ctrl_r;
      mask_nxt     = mask_r;
      stat_nxt     = stat_r;
      vec_nxt      = vec_r;
      lvl_nxt      = lvl_r;
      hs_acc_nxt   = hs_acc_r;
      hs_resp_nxt  = hs_resp_r;
      busy_nxt     = busy_r;
      end_seen_nxt = end_seen_r;
      wptr_nxt     = wptr_r;
      rptr_nxt     = rptr_r;
      exec_nxt     = 1'b0;
      rdata_nxt    = rdata_r;
      ack_nxt      = BUS_RD_I | BUS_WR_I;
      frame_nxt    = frame_r + 32'h0000_0001;
      disp_nxt     = disp_r;
      pc1_nxt      = pc1_r;
      pc2_nxt      = pc2_r;
      per_nxt      = 1'b0;
      fifo_wr      = 1'b0;

      // Event edge and capture
      evt_edge = EVENT_I & ~evt_d_r;
      capture  = evt_edge & ctrl_r[TPHI_CTRL_EVT_EN] & ~(ctrl_r[TPHI_CTRL_LOCKOUT] & locked_r);
      if (capture) begin
         evtime_nxt = TIME_I;
      end

      // Periodic divider, restarted on the epoch
      per_tick = 1'b0;
      if (EPOCH_I) begin
         pc1_nxt = 16'h0000;
         pc2_nxt = 16'h0000;
      end else if (pc1_r >= PER_N1_I) begin
         pc1_nxt = 16'h0000;
         if (pc2_r >= PER_N2_I) begin
            pc2_nxt  = 16'h0000;
            per_tick = 1'b1;
         end else begin
            pc2_nxt = pc2_r + 16'h0001;
         end
      end else begin
         pc1_nxt = pc1_r + 16'h0001;
      end
      per_nxt = per_tick;

      // Display advance inside the frame
      if (EPOCH_I) begin
         frame_nxt = 32'h0000_0000;
      end
      if (frame_r == DISP_ADV) begin
         disp_nxt = HMS_NEXT_I;
      end

      // Status events
      stat_set = '0;
      stat_set[TPHI_IRQ_EVENT]    = capture;
      stat_set[TPHI_IRQ_PERIODIC] = per_tick;
      stat_set[TPHI_IRQ_STROBE]   = STROBE_I;
      stat_set[TPHI_IRQ_EPOCH]    = EPOCH_I;
      stat_set[TPHI_IRQ_PACKET]   = RESP_READY_I;

      // Processor side of the packet store
      if (PKT_READ_I && busy_r && (rptr_r != wptr_r)) begin
         rptr_nxt = rptr_r + PW'(1);
      end

      // Register writes
      if (BUS_WR_I) begin
         unique case (BUS_ADDR_I)
            TPHI_OFF_CTRL:   ctrl_nxt = BUS_WDATA_I;
            TPHI_OFF_MASK:   mask_nxt = BUS_WDATA_I;
            TPHI_OFF_VECTOR: vec_nxt  = BUS_WDATA_I[TPHI_VECTOR_BITS-1:0];
            TPHI_OFF_LEVEL:  lvl_nxt  = BUS_WDATA_I[TPHI_LEVEL_BITS-1:0];
            TPHI_OFF_STATUS: stat_nxt = stat_r & ~BUS_WDATA_I[TPHI_IRQ_BITS-1:0];
            TPHI_OFF_FIFO: begin
               if (!busy_r && (wptr_r < PW'(FIFO_DEPTH))) begin
                  fifo_wr      = 1'b1;
                  wptr_nxt     = wptr_r + PW'(1);
                  end_seen_nxt = (BUS_WDATA_I[7:0] == TPHI_PKT_END);
               end
            end
            TPHI_OFF_HSHAKE: begin
               if (BUS_WDATA_I[TPHI_HS_RESP]) begin
                  hs_resp_nxt = 1'b0;
               end
               if (BUS_WDATA_I[TPHI_HS_EXEC]) begin
                  hs_acc_nxt = 1'b0;
                  if (end_seen_r && !busy_r) begin
                     busy_nxt = 1'b1;
                     exec_nxt = 1'b1;
                  end
               end
            end
            default: ;
         endcase
      end

      // Register reads and their side effects
      if (BUS_RD_I) begin
         rdata_nxt = TPHI_RST_WORD;
         if (BUS_ADDR_I == TPHI_OFF_LATCH) begin
            tlatch_nxt = TIME_I;
         end
         if (BUS_ADDR_I == TPHI_OFF_RELEASE) begin
            locked_nxt = 1'b0;
         end
         for (int i = 0; i < TPHI_TIME_WORDS; i++) begin
            if (BUS_ADDR_I == TPHI_OFF_TIME_WORD + 6'(2 * i)) begin
               rdata_nxt = tlatch_r[79 - 16 * i -: 16];
            end
            if (BUS_ADDR_I == TPHI_OFF_EVENT_TIME_FIRST_WORD + 6'(2 * i)) begin
               rdata_nxt = evtime_r[79 - 16 * i -: 16];
            end
         end
         unique case (BUS_ADDR_I)
            TPHI_OFF_HSHAKE: begin
               rdata_nxt[TPHI_HS_ACCEPT] = hs_acc_r;
               rdata_nxt[TPHI_HS_RESP]   = hs_resp_r;
            end
            TPHI_OFF_CTRL:   rdata_nxt = ctrl_r;
            TPHI_OFF_MASK:   rdata_nxt = mask_r;
            TPHI_OFF_STATUS: rdata_nxt[TPHI_IRQ_BITS-1:0] = stat_r;
            TPHI_OFF_VECTOR: rdata_nxt[TPHI_VECTOR_BITS-1:0] = vec_r;
            TPHI_OFF_LEVEL:  rdata_nxt[TPHI_LEVEL_BITS-1:0] = lvl_r;
            default: ;
         endcase
      end

      // Hardware sets win over clears
      if (capture) begin
         locked_nxt = 1'b1;
      end
      stat_nxt = stat_nxt | stat_set;
      if (RESP_READY_I) begin
         hs_resp_nxt = 1'b1;
      end
      if (PKT_ACCEPT_I && busy_r) begin
         hs_acc_nxt   = 1'b1;
         busy_nxt     = 1'b0;
         wptr_nxt     = '0;
         rptr_nxt     = '0;
         end_seen_nxt = 1'b0;
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         tlatch_r   <= '0;
         evtime_r   <= '0;
         locked_r   <= 1'b0;
         evt_d_r    <= 1'b0;
         ctrl_r     <= TPHI_RST_WORD;
         mask_r     <= TPHI_RST_WORD;
         stat_r     <= '0;
         vec_r      <= '0;
         lvl_r      <= '0;
         hs_acc_r   <= 1'b0;
         hs_resp_r  <= 1'b0;
         busy_r     <= 1'b0;
         end_seen_r <= 1'b0;
         wptr_r     <= '0;
         rptr_r     <= '0;
         exec_r     <= 1'b0;
         rdata_r    <= TPHI_RST_WORD;
         ack_r      <= 1'b0;
         frame_r    <= '0;
         disp_r     <= '0;
         pc1_r      <= '0;
         pc2_r      <= '0;
         per_r      <= 1'b0;
      end else begin
         tlatch_r   <= tlatch_nxt;
         evtime_r   <= evtime_nxt;
         locked_r   <= locked_nxt;
         evt_d_r    <= evt_d_nxt;
         ctrl_r     <= ctrl_nxt;
         mask_r     <= mask_nxt;
         stat_r     <= stat_nxt;
         vec_r      <= vec_nxt;
         lvl_r      <= lvl_nxt;
         hs_acc_r   <= hs_acc_nxt;
         hs_resp_r  <= hs_resp_nxt;
         busy_r     <= busy_nxt;
         end_seen_r <= end_seen_nxt;
         wptr_r     <= wptr_nxt;
         rptr_r     <= rptr_nxt;
         exec_r     <= exec_nxt;
         rdata_r    <= rdata_nxt;
         ack_r      <= ack_nxt;
         frame_r    <= frame_nxt;
         disp_r     <= disp_nxt;
         pc1_r      <= pc1_nxt;
         pc2_r      <= pc2_nxt;
         per_r      <= per_nxt;
      end
   end

   // ==========================================================
   // Packet byte store
   always_ff @(posedge SYS_CLK_I) begin
      if (fifo_wr) begin
         fifo_mem[wptr_r[FW-1:0]] <= BUS_WDATA_I[7:0];
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         pkt_data_r <= '0;
      end else begin
         pkt_data_r <= fifo_mem[rptr_nxt[FW-1:0]];
      end
   end

   // ==========================================================
   // Outputs
   assign BUS_RDATA_O  = rdata_r;
   assign BUS_ACK_O    = ack_r;
   assign PKT_EXEC_O   = exec_r;
   assign PKT_DATA_O   = pkt_data_r;
   assign PKT_VALID_O  = busy_r & (rptr_r != wptr_r);
   assign IRQ_O        = |(stat_r & mask_r[TPHI_IRQ_BITS-1:0]);
   assign IRQ_LEVEL_O  = lvl_r;
   assign IRQ_VECTOR_O = vec_r;
   assign PERIODIC_O   = per_r;
   assign DISP_HMS_O   = disp_r;
   assign DISP_DP_O    = FLYWHEEL_I;
endmodule : tphi_top

// File: test/tphi_monitor.sv
// Port checker of the time processor host interface
`timescale 1ns/10ps
module tphi_monitor (
   input wire logic        SYS_CLK_I,
   input wire logic        RST_N_I,
   input wire logic [5:0]  BUS_ADDR_I,
   input wire logic        BUS_RD_I,
   input wire logic        BUS_WR_I,
   input wire logic [15:0] BUS_WDATA_I,
   input wire logic [15:0] BUS_RDATA_O,
   input wire logic        BUS_ACK_O,
   input wire logic [79:0] TIME_I,
   input wire logic        PKT_EXEC_O,
   input wire logic        PKT_VALID_O,
   input wire logic [7:0]  PKT_DATA_O,
   input wire logic        PKT_ACCEPT_I,
   input wire logic        FLYWHEEL_I,
   input wire logic        DISP_DP_O
);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   // ==========================================================
   // Bus answer and time snapshot
   ack_follows_req_a: assert property ((BUS_RD_I || BUS_WR_I) |=> BUS_ACK_O)
      else $error("request without ack");
   ack_needs_req_a: assert property (!(BUS_RD_I || BUS_WR_I) |=> !BUS_ACK_O)
      else $error("ack without request");
   latch_reads_zero_a: assert property ((BUS_RD_I && BUS_ADDR_I == 6'h0a) |=> BUS_RDATA_O == 16'h0000)
      else $error("latch read not zero");
   snapshot_word_a: assert property ((BUS_RD_I && BUS_ADDR_I == 6'h0a) ##1 (BUS_RD_I && BUS_ADDR_I == 6'h0c)
      |=> BUS_RDATA_O == 16'($past(TIME_I, 2) >> 64))
      else $error("first time word differs from snapshot");
   // ==========================================================
   // Packet execution, acceptance and flywheel decimal points
   exec_needs_cmd_a: assert property (PKT_EXEC_O |-> $past(BUS_WR_I) && $past(BUS_ADDR_I) == 6'h22
      && ($past(BUS_WDATA_I) & 16'h0080) != 16'h0000)
      else $error("execute without command write");
   exec_single_a: assert property (PKT_EXEC_O |=> !PKT_EXEC_O)
      else $error("execute longer than one cycle");
   exec_first_byte_a: assert property (PKT_EXEC_O |-> PKT_VALID_O && PKT_DATA_O == 8'h01)
      else $error("packet does not start with start byte");
   accept_bit_a: assert property (PKT_ACCEPT_I ##1 (BUS_RD_I && BUS_ADDR_I == 6'h22) |=> BUS_RDATA_O[0])
      else $error("accept not shown in handshake");
   flywheel_dots_a: assert property (DISP_DP_O == FLYWHEEL_I)
      else $error("decimal points do not follow flywheel");
endmodule : tphi_monitor

// File: test/tphi_proc_model.sv
// Processor side model that drains and accepts packets
`timescale 1ns/10ps
module tphi_proc_model (
   input  wire logic       SYS_CLK_I,
   input  wire logic       PKT_EXEC_O,
   input  wire logic       PKT_VALID_O,
   input  wire logic [7:0] PKT_DATA_O,
   output logic            PKT_READ_I = 1'b0,
   output logic            PKT_ACCEPT_I = 1'b0
);
   logic [7:0] rx[$];
   logic       busy = 1'b0;
   // ==========================================================
   // Drain one byte every other cycle, then accept
   always @(negedge SYS_CLK_I) begin
      if (PKT_EXEC_O) begin
         busy = 1'b1;
      end
      if (!PKT_READ_I && PKT_VALID_O) begin
         rx.push_back(PKT_DATA_O);
         PKT_READ_I = 1'b1;
         PKT_ACCEPT_I = 1'b0;
      end else if (busy && !PKT_VALID_O && !PKT_READ_I) begin
         busy = 1'b0;
         PKT_READ_I = 1'b0;
         PKT_ACCEPT_I = 1'b1;
      end else begin
         PKT_READ_I = 1'b0;
         PKT_ACCEPT_I = 1'b0;
      end
   end
endmodule : tphi_proc_model

// File: test/tb_time_processor_host_interface.sv
// Testbench of the time processor host interface
`timescale 1ns/10ps
module tb_time_processor_host_interface;
   import tphi_pkg::*;
   logic        SYS_CLK_I, RST_N_I, BUS_RD_I, BUS_WR_I, EPOCH_I, EVENT_I, STROBE_I, FLYWHEEL_I, RESP_READY_I;
   logic        BUS_ACK_O, PKT_EXEC_O, PKT_VALID_O, PKT_READ_I, PKT_ACCEPT_I, IRQ_O, PERIODIC_O, DISP_DP_O;
   logic [5:0]  BUS_ADDR_I;
   logic [15:0] BUS_WDATA_I, BUS_RDATA_O, PER_N1_I, PER_N2_I, rdat;
   logic [7:0]  PKT_DATA_O, IRQ_VECTOR_O;
   logic [2:0]  IRQ_LEVEL_O;
   logic [79:0] TIME_I, snap;
   logic [23:0] HMS_NEXT_I, DISP_HMS_O;
   logic [7:0]  pk[$];
   int          errors, comparisons, n;
   string       s;
   tphi_top #(.DISP_ADV_CYC(50)) dut (.*);
   tphi_proc_model u_proc (.*);
   always #20 SYS_CLK_I = ~SYS_CLK_I;
   // ==========================================================
   // Tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
      BUS_RD_I = !w;
      BUS_WR_I = w;
      BUS_ADDR_I = a;
      BUS_WDATA_I = d;
      @(negedge SYS_CLK_I);
      rdat = BUS_RDATA_O;
   endtask : bus
   task automatic idle(input int c);
      BUS_RD_I = 1'b0;
      BUS_WR_I = 1'b0;
      repeat (c) @(negedge SYS_CLK_I);
   endtask : idle
   task automatic pulse(ref logic p);
      p = 1'b1;
      @(negedge SYS_CLK_I);
      p = 1'b0;
   endtask : pulse
   task automatic send_cmd();
      foreach (pk[i]) bus(1'b1, TPHI_OFF_FIFO, {8'h00, pk[i]});
      bus(1'b1, TPHI_OFF_HSHAKE, 16'h0081);
      n = 0;
      do begin
         bus(1'b0, TPHI_OFF_HSHAKE, 16'h0000);
         n++;
      end while (rdat[0] !== 1'b1 && n < 300);
      idle(1);
   endtask : send_cmd
   task automatic send_str(input string t);
      u_proc.rx.delete();
      pk = {8'h01};
      foreach (t[i]) pk.push_back(t[i]);
      pk.push_back(8'h17);
      send_cmd();
      chk("packet length", pk.size(), u_proc.rx.size());
   endtask : send_str
   task automatic summarize();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   // ==========================================================
   // Watchdog
   initial begin
      repeat (5000) @(posedge SYS_CLK_I);
      errors++;
      summarize();
   end
   // ==========================================================
   // Tests
   initial begin
      {SYS_CLK_I, RST_N_I, BUS_RD_I, BUS_WR_I, EPOCH_I, EVENT_I, STROBE_I, FLYWHEEL_I, RESP_READY_I} = '0;
      {BUS_ADDR_I, BUS_WDATA_I, HMS_NEXT_I} = '0;
      PER_N1_I = 16'h0001;
      PER_N2_I = 16'h0002;
      snap = 80'h1111_2222_3333_4444_5555;
      TIME_I = snap;
      repeat (16) @(negedge SYS_CLK_I);
      RST_N_I = 1'b1;
      repeat (3) @(negedge SYS_CLK_I);
      bus(1'b0, TPHI_OFF_LATCH, 16'h0000);
      TIME_I = ~snap;
      chk("latch read", 0, rdat);
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, 6'(TPHI_OFF_TIME_WORD + 2 * i), 16'h0000);
         chk("time word", snap[79 - 16 * i -: 16], rdat);
      end
      idle(1);
      $display("end of latch test");
      bus(1'b1, TPHI_OFF_CTRL, 16'h0009);
      bus(1'b1, TPHI_OFF_VECTOR, 16'h0040);
      bus(1'b1, TPHI_OFF_LEVEL, 16'h0003);
      bus(1'b1, TPHI_OFF_STATUS, 16'h0001);
      bus(1'b1, TPHI_OFF_MASK, 16'h0001);
      idle(1);
      chk("level", 3, IRQ_LEVEL_O);
      chk("vector", 8'h40, IRQ_VECTOR_O);
      chk("irq quiet", 0, IRQ_O);
      TIME_I = snap;
      EVENT_I = 1'b1;
      @(negedge SYS_CLK_I);
      TIME_I = ~snap;
      idle(2);
      chk("irq on event", 1, IRQ_O);
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, 6'(TPHI_OFF_EVENT_TIME_FIRST_WORD + 2 * i), 16'h0000);
         chk("event word", snap[79 - 16 * i -: 16], rdat);
      end
      EVENT_I = 1'b0;
      idle(1);
      pulse(EVENT_I);
      idle(1);
      bus(1'b0, TPHI_OFF_EVENT_TIME_FIRST_WORD, 16'h0000);
      chk("event locked", snap[79:64], rdat);
      bus(1'b0, TPHI_OFF_RELEASE, 16'h0000);
      bus(1'b1, TPHI_OFF_STATUS, 16'h0001);
      idle(2);
      chk("irq cleared", 0, IRQ_O);
      EVENT_I = 1'b0;
      idle(1);
      pulse(EVENT_I);
      idle(1);
      bus(1'b0, TPHI_OFF_EVENT_TIME_FIRST_WORD, 16'h0000);
      chk("event after release", snap[79:64] ^ 16'hffff, rdat);
      idle(1);
      $display("end of event test");
      bus(1'b1, TPHI_OFF_MASK, 16'h0008);
      bus(1'b1, TPHI_OFF_STATUS, 16'h001f);
      HMS_NEXT_I = 24'h123456;
      idle(1);
      pulse(EPOCH_I);
      idle(1);
      chk("irq on epoch", 1, IRQ_O);
      bus(1'b0, TPHI_OFF_STATUS, 16'h0000);
      chk("epoch status", 16'h0008, rdat & 16'h0008);
      bus(1'b1, TPHI_OFF_STATUS, 16'h0008);
      idle(2);
      chk("epoch cleared", 0, IRQ_O);
      idle(30);
      chk("display early", 0, DISP_HMS_O);
      idle(25);
      chk("display advanced", 24'h123456, DISP_HMS_O);
      FLYWHEEL_I = 1'b1;
      idle(1);
      chk("decimal points", 1, DISP_DP_O);
      n = 0;
      while (PERIODIC_O !== 1'b1 && n < 50) begin
         idle(1);
         n++;
      end
      idle(1);
      n = 1;
      while (PERIODIC_O !== 1'b1 && n < 50) begin
         idle(1);
         n++;
      end
      chk("periodic spacing", 6, n);
      $display("end of timing test");
      pk = {8'h01, 8'h41, 8'h31};
      foreach (pk[i]) bus(1'b1, TPHI_OFF_FIFO, {8'h00, pk[i]});
      bus(1'b1, TPHI_OFF_HSHAKE, 16'h0081);
      idle(10);
      chk("early execute", 0, u_proc.rx.size());
      pk = {8'h17};
      send_cmd();
      pk = {8'h01, 8'h41, 8'h31, 8'h17};
      chk("accepted", 1, rdat[0]);
      foreach (pk[i]) chk("held byte", pk[i], u_proc.rx[i]);
      u_proc.rx.delete();
      s = "F500630063";
      pk = {8'h01};
      foreach (s[i]) pk.push_back(s[i]);
      pk.push_back(8'h17);
      send_cmd();
      chk("packet length", pk.size(), u_proc.rx.size());
      foreach (pk[i]) chk("packet byte", pk[i], u_proc.rx[i]);
      pulse(RESP_READY_I);
      bus(1'b0, TPHI_OFF_HSHAKE, 16'h0000);
      chk("response ready", 1, rdat[2]);
      bus(1'b1, TPHI_OFF_HSHAKE, 16'h0004);
      bus(1'b0, TPHI_OFF_HSHAKE, 16'h0000);
      chk("response cleared", 0, rdat[2]);
      idle(1);
      send_str("A1");
      bus(1'b1, TPHI_OFF_STATUS, 16'h0008);
      idle(1);
      pulse(EPOCH_I);
      bus(1'b0, TPHI_OFF_STATUS, 16'h0000);
      chk("epoch before time", 1, rdat[3]);
      send_str("B123112233");
      chk("time packet tag", 8'h42, u_proc.rx[1]);
      send_str("P04");
      chk("path lower nibble", 8'h34, u_proc.rx[3]);
      $display("end of packet test");
      summarize();
   end
endmodule : tb_time_processor_host_interface
bind tphi_top tphi_monitor mon (.*);
